// [rtl/io_lines_keyscan_counters.v]
// 24-line general-purpose port: line and byte-group access, key matrix scan,
// per-line edge interrupts and 32-bit edge counters, behind an APB slave.
// Assumes APB inputs are synchronous to pclk; line_in passes a two-stage synchroniser; the pads combine out/oe_n/pull-up.
//
// Behaviour
// - The port has 24 lines 0..23, and a higher line always takes a higher bit in any grouped view.
// - Every line has a pull-up that software switches on or off for that line alone.
// - Once the port is enabled each line is writable as an output and readable as an input.
// - Low, middle and top byte groups map lines 7..0, 15..8, 23..16 and a write sets all eight.
// - The even-line group holds lines 14,12,...,0 from bit 7 down to bit 0.
// - The odd-line group holds lines 15,13,...,1 from bit 7 down to bit 0.
// - In key-scan mode the 24 lines scan a matrix of up to 276 keys, one per pair of lines.
// - A key press raises a key event that identifies the pressed key.
// - Two keys pressed together are both resolved without diodes only when they share no line.
// - A line set for interrupt raises an event on each edge of its selected polarity, falling after reset.
// - There are 24 unsigned 32-bit edge counters, one per line, each readable.
// - A counter counts only while its line is in interrupt mode, with no handler needed.
// - A counter steps by one on the edge polarity selected for that line's interrupt.
// - Resetting one counter zeroes it and leaves the others alone.
// - Counters register edges arriving at up to about ten kilohertz.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "io_lines_consts.vh"

module io_lines_keyscan_counters (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [23:0] line_in,
  output reg  [23:0] line_out,
  output reg  [23:0] line_oe_n,
  output reg  [23:0] pullup_en,
  output reg         irq
);

  // ==========================================================
  // Register state
  reg  [1:0]  ctrl_q;
  reg  [23:0] out_val_q;
  reg  [23:0] out_en_q;
  reg  [23:0] pullup_q;
  reg  [23:0] int_en_q;
  reg  [23:0] edge_pol_q;
  reg  [24:0] stat_q;
  reg  [24:0] mask_q;
  reg  [31:0] cnt_q [0:23];
  reg  [23:0] sync1_q;
  reg  [23:0] sync2_q;
  reg  [23:0] prev_q;
  reg  [8:0]  div_q;
  reg  [4:0]  scan_idx_q;
  reg  [9:0]  found_a_q;
  reg  [9:0]  found_b_q;
  reg  [1:0]  found_n_q;
  reg  [9:0]  key_a_q;
  reg  [9:0]  key_b_q;
  reg  [1:0]  key_n_q;

  wire        port_en = ctrl_q[`CTRL_PORT_EN];
  wire        scan_en = ctrl_q[`CTRL_SCAN_EN] & port_en;
  wire        setup_ph = psel & ~penable;
  wire        wr = psel & penable & pwrite & pready;
  wire        scan_tick = scan_en & (div_q == 9'd0);
  wire [23:0] rise = sync2_q & ~prev_q; // Checked every cycle, far above 10 kHz
  wire [23:0] fall = ~sync2_q & prev_q;
  // Counting needs only interrupt mode, not an enabled interrupt output
  wire [23:0] line_evt = int_en_q & ((edge_pol_q & rise) | (~edge_pol_q & fall));

  // ==========================================================
  // Group views and event bits
  reg  [7:0]  even_in;
  reg  [7:0]  odd_in;
  reg  [23:0] grp_val;
  reg  [23:0] grp_msk;
  reg         hit;
  reg  [4:0]  hit_line;
  reg         key_new;
  // One loop index per process, so no process wakes another through it
  integer     gi;
  integer     wi;
  integer     ci;
  integer     hi;

  // Interleaved groups; bit 7 is always the higher line
  always @* begin
    for (gi = 0; gi < 8; gi = gi + 1) begin
      even_in[gi] = sync2_q[2 * gi];
      odd_in[gi]  = sync2_q[2 * gi + 1];
    end
  end

  // Bits touched by a group or single-line write, and their new values
  always @* begin
    grp_val = 24'h00_0000;
    grp_msk = 24'h00_0000;
    if (wr) begin
      case (paddr)
        `REG_LOW_GRP: begin
          grp_msk = 24'h00_00FF;
          grp_val = {16'h0000, pwdata[7:0]};
        end
        `REG_MID_GRP: begin
          grp_msk = 24'h00_FF00;
          grp_val = {8'h00, pwdata[7:0], 8'h00};
        end
        `REG_TOP_GRP: begin
          grp_msk = 24'hFF_0000;
          grp_val = {pwdata[7:0], 16'h0000};
        end
        `REG_EVEN_GRP: begin
          for (wi = 0; wi < 8; wi = wi + 1) begin
            grp_msk[2 * wi] = 1'b1;
            grp_val[2 * wi] = pwdata[wi];
          end
        end
        `REG_ODD_GRP: begin
          for (wi = 0; wi < 8; wi = wi + 1) begin
            grp_msk[2 * wi + 1] = 1'b1;
            grp_val[2 * wi + 1] = pwdata[wi];
          end
        end
        `REG_LINE_SET: begin
          grp_msk = pwdata[23:0];
          grp_val = 24'hFF_FFFF;
        end
        `REG_LINE_CLR: begin
          grp_msk = pwdata[23:0];
          grp_val = 24'h00_0000;
        end
        default: begin
          grp_msk = 24'h00_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // APB slave: read data is captured in setup, so access needs no wait
  reg [31:0] rd_d;
  reg        err_d;

  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (paddr)
      `REG_CTRL:     rd_d = {30'h0000_0000, ctrl_q};
      `REG_OUT_VAL:  rd_d = {8'h00, out_val_q};
      `REG_OUT_EN:   rd_d = {8'h00, out_en_q};
      `REG_PULLUP:   rd_d = {8'h00, pullup_q};
      `REG_IN_VAL:   rd_d = {8'h00, sync2_q};
      `REG_LOW_GRP:  rd_d = {24'h00_0000, sync2_q[7:0]};
      `REG_MID_GRP:  rd_d = {24'h00_0000, sync2_q[15:8]};
      `REG_TOP_GRP:  rd_d = {24'h00_0000, sync2_q[23:16]};
      `REG_EVEN_GRP: rd_d = {24'h00_0000, even_in};
      `REG_ODD_GRP:  rd_d = {24'h00_0000, odd_in};
      `REG_LINE_SET: rd_d = 32'h0000_0000;
      `REG_LINE_CLR: rd_d = 32'h0000_0000;
      `REG_INT_EN:   rd_d = {8'h00, int_en_q};
      `REG_EDGE_POL: rd_d = {8'h00, edge_pol_q};
      `REG_IRQ_STAT: rd_d = {7'h00, stat_q};
      `REG_IRQ_MASK: rd_d = {7'h00, mask_q};
      `REG_KEY_STAT: rd_d = {10'h000, key_n_q, key_b_q, key_a_q};
      default: begin
        // Counter window; anything else answers with an error and zero data
        if (paddr[7] && (paddr[6:2] < 5'd24) && (paddr[1:0] == 2'b00))
          rd_d = cnt_q[paddr[6:2]];
        else
          err_d = 1'b1;
      end
    endcase
  end

  // Ready and answer registered one cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & err_d;
      if (setup_ph)
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  // ==========================================================
  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `RST_CTRL;
      out_val_q  <= `RST_LINES;
      out_en_q   <= `RST_LINES;
      pullup_q   <= `RST_LINES;
      int_en_q   <= `RST_LINES;
      edge_pol_q <= `RST_POL;
      mask_q     <= `RST_STAT;
    end else begin
      out_val_q <= (out_val_q & ~grp_msk) | (grp_val & grp_msk);
      if (wr) begin
        case (paddr)
          `REG_CTRL:     ctrl_q     <= pwdata[1:0];
          `REG_OUT_VAL:  out_val_q  <= pwdata[23:0];
          `REG_OUT_EN:   out_en_q   <= pwdata[23:0];
          `REG_PULLUP:   pullup_q   <= pwdata[23:0];
          `REG_INT_EN:   int_en_q   <= pwdata[23:0];
          `REG_EDGE_POL: edge_pol_q <= pwdata[23:0]; // Zero selects falling
          `REG_IRQ_MASK: mask_q     <= pwdata[24:0];
          default:       mask_q     <= mask_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Input synchroniser and edge history
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 24'hFF_FFFF;
      sync2_q <= 24'hFF_FFFF;
      prev_q  <= 24'hFF_FFFF;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ==========================================================
  // Edge counters; a clear that meets an edge leaves a count of one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (ci = 0; ci < 24; ci = ci + 1)
        cnt_q[ci] <= 32'h0000_0000;
    end else begin
      for (ci = 0; ci < 24; ci = ci + 1) begin
        if (wr && paddr[7] && (paddr[6:2] == ci[4:0]) && (paddr[1:0] == 2'b00))
          cnt_q[ci] <= {31'h0000_0000, line_evt[ci]};
        else if (line_evt[ci])
          cnt_q[ci] <= cnt_q[ci] + 32'h0000_0001; // Wraps at the top
      end
    end
  end

  // ==========================================================
  // Key scan: drive one line low per step, look for higher lines pulled low.
  // Each key pair is seen once, from its lower line. Two keys sharing a line
  // short three lines together and cannot be told apart without diodes.
  always @* begin
    hit      = 1'b0;
    hit_line = 5'h00;
    for (hi = 23; hi >= 0; hi = hi - 1) begin
      if ((hi[4:0] > scan_idx_q) && !sync2_q[hi]) begin
        hit      = 1'b1;
        hit_line = hi[4:0];
      end
    end
  end

  // New key set at the end of a sweep that differs from the last one
  always @* begin
    key_new = scan_tick && (scan_idx_q == `LAST_LINE) && (found_n_q != 2'd0) &&
              ({found_n_q, found_b_q, found_a_q} != {key_n_q, key_b_q, key_a_q});
  end

  // Step divider and sweep state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q      <= 9'd0;
      scan_idx_q <= 5'h00;
      found_a_q  <= 10'h000;
      found_b_q  <= 10'h000;
      found_n_q  <= 2'd0;
      key_a_q    <= 10'h000;
      key_b_q    <= 10'h000;
      key_n_q    <= 2'd0;
    end else if (!scan_en) begin
      div_q      <= 9'd0;
      scan_idx_q <= 5'h00;
      found_n_q  <= 2'd0;
    end else begin
      div_q <= (div_q == `SCAN_STEP_CYC - 1) ? 9'd0 : div_q + 9'd1;
      if (scan_tick) begin
        if (scan_idx_q == `LAST_LINE) begin
          // Publish the sweep; up to two keys kept for shift use
          key_a_q    <= found_a_q;
          key_b_q    <= found_b_q;
          key_n_q    <= found_n_q;
          found_n_q  <= 2'd0;
          scan_idx_q <= 5'h00;
        end else begin
          if (hit && (found_n_q == 2'd0)) begin
            found_a_q <= {hit_line, scan_idx_q};
            found_n_q <= 2'd1;
          end else if (hit && (found_n_q == 2'd1)) begin
            found_b_q <= {hit_line, scan_idx_q};
            found_n_q <= 2'd2;
          end
          scan_idx_q <= scan_idx_q + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // Sticky status, write one to clear; a new event beats the clear
  reg [24:0] stat_set;
  reg [24:0] stat_clr;

  always @* begin
    stat_set = {key_new, line_evt & int_en_q};
    stat_clr = (wr && (paddr == `REG_IRQ_STAT)) ? pwdata[24:0] : 25'h000_0000;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= `RST_STAT;
      irq    <= 1'b0;
    end else begin
      stat_q <= stat_set | (stat_q & ~stat_clr);
      irq    <= |((stat_set | (stat_q & ~stat_clr)) & mask_q);
    end
  end

  // ==========================================================
  // Pad controls; scan overrides the output registers while it runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_out  <= 24'h00_0000;
      line_oe_n <= 24'hFF_FFFF;
      pullup_en <= 24'h00_0000;
    end else if (scan_en) begin
      line_out  <= 24'h00_0000;
      line_oe_n <= ~(24'h00_0001 << scan_idx_q);
      pullup_en <= 24'hFF_FFFF; // Undriven lines must idle high to be read
    end else begin
      line_out  <= out_val_q;
      line_oe_n <= port_en ? ~out_en_q : 24'hFF_FFFF;
      pullup_en <= pullup_q;
    end
  end

endmodule

// [rtl/io_lines_consts.vh]
// Constants for the 24-line port with key scan and edge counters.
// Assumes byte addresses on an 8-bit APB address, 32-bit data, 40 MHz pclk.
`ifndef IO_LINES_CONSTS_VH
`define IO_LINES_CONSTS_VH

// ==========================================================
// Geometry
`define NUM_LINES        24
`define CNT_WIDTH        32

// ==========================================================
// Register byte offsets
`define REG_CTRL         8'h00
`define REG_OUT_VAL      8'h04
`define REG_OUT_EN       8'h08
`define REG_PULLUP       8'h0C
`define REG_IN_VAL       8'h10
`define REG_LOW_GRP      8'h14
`define REG_MID_GRP      8'h18
`define REG_TOP_GRP      8'h1C
`define REG_EVEN_GRP     8'h20
`define REG_ODD_GRP      8'h24
`define REG_LINE_SET     8'h28
`define REG_LINE_CLR     8'h2C
`define REG_INT_EN       8'h30
`define REG_EDGE_POL     8'h34
`define REG_IRQ_STAT     8'h38
`define REG_IRQ_MASK     8'h3C
`define REG_KEY_STAT     8'h40
// Counters sit at COUNT_BASE + 4 * line, lines 0..23
`define COUNT_BASE       8'h80

// ==========================================================
// Field positions
`define CTRL_PORT_EN     0
`define CTRL_SCAN_EN     1
`define KEY_EVT_BIT      24
`define STAT_WIDTH       25

// ==========================================================
// Reset values
`define RST_CTRL         2'h0
`define RST_LINES        24'h00_0000
`define RST_POL          24'h00_0000
`define RST_STAT         25'h000_0000

// ==========================================================
// Timing: dwell time on each driven scan line
`define CLK_PERIOD_NS    25
`define SCAN_STEP_NS     10000
`define SCAN_STEP_CYC    ((`SCAN_STEP_NS) / (`CLK_PERIOD_NS))
`define LAST_LINE        5'h17

`endif

// [testbench/io_lines_sva.sv]
// Checker for the 24-line port: APB answer, group writes, masking, scan.
// Assumes the byte offsets of io_lines_consts.vh; bound to every instance.
`timescale 1ns/1ps
`include "io_lines_consts.vh"
module io_lines_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [23:0] line_in,
  input wire [23:0] line_out,
  input wire [23:0] line_oe_n,
  input wire [23:0] pullup_en,
  input wire        irq
);
  reg  [1:0] ctrl_q;
  wire       wr = psel && penable && pready && pwrite;
  wire       nscan = !ctrl_q[1];
  // Shadow control, so group checks stay quiet while the scan owns the lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= 2'h0;
    else if (wr && paddr == `REG_CTRL)
      ctrl_q <= pwdata[1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_ONE: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_NO_CNT_25: assert property (psel && penable && pready && paddr == 8'hE0 |-> pslverr)
    else $error("address past last counter accepted");
  AST_PORT_OFF: assert property (wr && paddr == `REG_CTRL && !pwdata[0]
    |-> ##[1:2] line_oe_n == 24'hFF_FFFF)
    else $error("disabled port still drives");
  AST_TOP_GRP: assert property (nscan && wr && paddr == `REG_TOP_GRP
    |-> ##[1:2] line_out[23:16] == $past(pwdata[7:0], 2))
    else $error("top group write lost");
  AST_EVEN_GRP: assert property (nscan && wr && paddr == `REG_EVEN_GRP
    |-> ##2 {line_out[14], line_out[0]} == $past({pwdata[7], pwdata[0]}, 2))
    else $error("even group write misplaced");
  AST_ODD_GRP: assert property (nscan && wr && paddr == `REG_ODD_GRP
    |-> ##2 {line_out[15], line_out[1]} == $past({pwdata[7], pwdata[0]}, 2))
    else $error("odd group write misplaced");
  AST_IRQ_MASK: assert property (wr && paddr == `REG_IRQ_MASK && pwdata[24:0] == 25'h0
    |-> ##2 !irq [*2])
    else $error("masked interrupt still high");
  AST_SCAN_LINES: assert property (ctrl_q[1] && $past(ctrl_q[1], 3)
    |-> $onehot0(~line_oe_n) && (line_out & ~line_oe_n) == 24'h00_0000
    && pullup_en == 24'hFF_FFFF)
    else $error("scan drives wrongly");
endmodule
bind io_lines_keyscan_counters io_lines_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
  .line_out(line_out), .line_oe_n(line_oe_n), .pullup_en(pullup_en), .irq(irq));

// [testbench/line_partner.sv]
// Pad model: ground switches, drivers, pull-ups and two matrix keys.
// Assumes active-low enables; a floating line toggles so it never looks stable.
`timescale 1ns/1ps
module line_partner (
  input  wire        pclk,
  input  wire [23:0] line_out,
  input  wire [23:0] line_oe_n,
  input  wire [23:0] pullup_en,
  input  wire [23:0] gnd_sw,
  input  wire [19:0] keys,
  input  wire [1:0]  key_on,
  output reg  [23:0] line_in
);
  reg [23:0] lvl;
  reg        float_q = 1'b0;
  integer    i;
  always @(posedge pclk) float_q <= ~float_q;
  // A key shorts two lines, so a low on either pulls both low
  always @* begin
    for (i = 0; i < 24; i = i + 1)
      lvl[i] = gnd_sw[i] ? 1'b0 : !line_oe_n[i] ? line_out[i] : pullup_en[i] | float_q;
    line_in = lvl;
    for (i = 0; i < 2; i = i + 1) begin
      if (key_on[i]) begin
        line_in[keys[i*10 +: 5]] = lvl[keys[i*10 +: 5]] & lvl[keys[i*10+5 +: 5]];
        line_in[keys[i*10+5 +: 5]] = line_in[keys[i*10 +: 5]];
      end
    end
  end
endmodule

// [testbench/io_lines_keyscan_counters_bench.sv]
// Self-checking bench: APB master tasks, one task per scenario.
// Assumes the pad model for line levels and a 40 MHz pclk.
`timescale 1ns/1ps
`include "io_lines_consts.vh"
module io_lines_keyscan_counters_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [23:0] gnd_sw = 24'h00_0000;
  reg  [19:0] keys = 20'h0_0000;
  reg  [1:0]  key_on = 2'h0;
  reg  [31:0] rd_q;
  reg         err_q;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  wire [23:0] line_in;
  wire [23:0] line_out;
  wire [23:0] line_oe_n;
  wire [23:0] pullup_en;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  io_lines_keyscan_counters dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
    .line_oe_n(line_oe_n), .pullup_en(pullup_en), .irq(irq));
  line_partner pads (.pclk(pclk), .line_out(line_out), .line_oe_n(line_oe_n),
    .pullup_en(pullup_en), .gnd_sw(gnd_sw), .keys(keys), .key_on(key_on),
    .line_in(line_in));
  always #12.5 pclk = ~pclk;
  // ==========================================================
  // Shared tasks
  task conclude;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // A hang in a handshake wait ends here
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Request held until pready is seen high; data taken at that edge only
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task pulse(input [23:0] m);
    begin
      gnd_sw <= m;
      repeat (4) @(posedge pclk);
      gnd_sw <= 24'h00_0000;
      repeat (4) @(posedge pclk);
    end
  endtask
  // Registered pad outputs and the two-stage input path lag a write by a few edges
  task settle;
    begin
      repeat (4) @(posedge pclk);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      chk({line_oe_n, pullup_en[7:0]}, 32'hFFFF_FF00);
      apb(0, `REG_EDGE_POL, 0);
      chk(rd_q, 0);
      apb(0, 8'hE0, 0);
      chk(err_q, 1);
    end
  endtask
  task t_groups;
    begin
      apb(1, `REG_CTRL, 1);
      apb(1, `REG_OUT_EN, 24'hFF_FFFF);
      apb(1, `REG_LOW_GRP, 8'hA5);
      apb(1, `REG_MID_GRP, 8'h3C);
      apb(1, `REG_TOP_GRP, 8'h81);
      settle;
      chk(line_out, 32'h0081_3CA5);
      apb(1, `REG_EVEN_GRP, 8'h00);
      settle;
      chk(line_out, 32'h0081_28A0);
      apb(1, `REG_ODD_GRP, 8'hFF);
      settle;
      chk(line_out, 32'h0081_AAAA);
      apb(1, `REG_LINE_CLR, 24'h80_0000);
      apb(1, `REG_LINE_SET, 24'h00_0001);
      settle;
      apb(0, `REG_IN_VAL, 0);
      chk(rd_q, 32'h0001_AAAB);
      apb(0, `REG_EVEN_GRP, 0);
      chk(rd_q, 32'h0000_0001);
      apb(0, `REG_ODD_GRP, 0);
      chk(rd_q, 32'h0000_00FF);
      apb(1, `REG_OUT_EN, 0);
      apb(1, `REG_PULLUP, 24'hF0_0F00);
      settle;
      chk(pullup_en, 32'h00F0_0F00);
      apb(0, `REG_IN_VAL, 0);
      chk(rd_q & 32'h00F0_0F00, 32'h00F0_0F00);
      apb(1, `REG_PULLUP, 24'hFF_FFFF);
    end
  endtask
  task t_counters;
    begin
      apb(1, `REG_INT_EN, 1);
      apb(1, `REG_IRQ_MASK, 1);
      repeat (3) pulse(24'h00_0003);
      apb(0, `COUNT_BASE, 0);
      chk(rd_q, 3);
      apb(0, `COUNT_BASE + 8'h04, 0);
      chk(rd_q, 0);
      chk(irq, 1);
      apb(1, `REG_IRQ_MASK, 0);
      apb(0, `REG_IRQ_STAT, 0);
      chk({irq, rd_q[24:0]}, 32'h0000_0001);
      apb(1, `REG_EDGE_POL, 1);
      apb(1, `REG_INT_EN, 3);
      apb(1, `COUNT_BASE, 0);
      repeat (2) pulse(24'h00_0003);
      apb(1, `COUNT_BASE + 8'h04, 0);
      apb(0, `COUNT_BASE, 0);
      chk(rd_q, 2);
      apb(0, `COUNT_BASE + 8'h04, 0);
      chk(rd_q, 0);
      apb(1, `REG_IRQ_STAT, 25'h1FF_FFFF);
      apb(0, `REG_IRQ_STAT, 0);
      chk(rd_q, 0);
    end
  endtask
  task t_keyscan;
    begin
      apb(1, `REG_INT_EN, 0);
      apb(1, `REG_IRQ_MASK, 25'h100_0000);
      keys <= {5'd9, 5'd4, 5'd7, 5'd2};
      key_on <= 2'b11;
      apb(1, `REG_CTRL, 3);
      repeat (48 * `SCAN_STEP_CYC + 50) @(posedge pclk);
      chk(irq, 1);
      apb(0, `REG_KEY_STAT, 0);
      chk(rd_q, {10'h0, 2'd2, 5'd9, 5'd4, 5'd7, 5'd2});
      key_on <= 2'b00;
      repeat (48 * `SCAN_STEP_CYC) @(posedge pclk);
      apb(0, `REG_KEY_STAT, 0);
      chk(rd_q[21:20], 0);
      apb(1, `REG_CTRL, 0);
      settle;
      chk(line_oe_n, 32'h00FF_FFFF);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_groups;
    t_counters;
    t_keyscan;
    conclude;
  end
endmodule
